// ### verilog/asp_serial_port.sv
// Serial control and readout port of a multi-channel sigma-delta converter.
// Assumes the host is serial master on sclk, and the filter core presents each
// new result as a one-cycle conv_valid pulse on mclk.
`timescale 1ns/1ps
module asp_serial_port
   import asp_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        din,
   input  wire logic        reset_n,
   output logic             dout,
   output logic             dout_oe,
   output logic             data_ready_n,
   input  wire logic        conv_valid,
   input  wire logic [15:0] conv_data,
   input  wire logic        cal_done,
   output logic [7:0]       setup_reg,
   output logic [7:0]       clock_reg,
   output logic             filter_reset
);

   // Serial-clock domain state.
   logic        link_arst;
   logic        frame_arst;
   asp_phase_t  phase_q;
   logic [7:0]  comm_q;
   logic [3:0]  bits_q;
   logic [6:0]  sin_q;
   logic        rd_load_q;
   logic [15:0] sout_q;
   logic        wr_tgl_q;
   logic [2:0]  wr_sel_q;
   logic [7:0]  wr_data_q;
   logic        rd_tgl_q;
   logic        data_ready_n_link;
   logic [7:0]  byte_in;
   logic [2:0]  rs_sel;
   logic        last_bit;
   logic [15:0] read_word;

   // Master-clock domain state.
   logic        pin_rst_n_s;
   logic        ctrl_rst;
   logic        wr_tgl_s;
   logic        rd_tgl_s;
   logic        wr_seen_q;
   logic        rd_seen_q;
   logic        wr_ev;
   logic        rd_ev;
   logic [7:0]  setup_q;
   logic [7:0]  clock_q;
   logic [15:0] data_q;
   logic [15:0] pend_q;
   logic        data_ready_n_n_q;
   logic        filt_rst_q;
   logic        cal_active;
   logic        cal_start;
   logic        cal_fin;
   logic        imm_commit;
   logic        hold_start;
   logic        commit;

   asp_hold_if hold_bus ();

   // The reset pin clears the link asynchronously; a glitch on it is taken as a reset.
   assign link_arst  = rst | ~reset_n; // [RULE3]
   // Raising chip select drops any partial byte, which realigns a framed host.
   assign frame_arst = link_arst | cs_n; // [RULE4] [RULE6]

   assign byte_in  = {sin_q, din};
   assign rs_sel   = comm_q[COMM_RS_MSB:COMM_RS_LSB];
   assign last_bit = (bits_q == asp_last_idx(phase_q, rs_sel));

   // Bit counter inside a byte or data word; it only moves on host clock edges, so
   // pauses between bursts leave it where it was.
   always_ff @(posedge sclk or posedge frame_arst)
   begin
      if (frame_arst)
         bits_q <= 4'h0;
      else if (last_bit)
         bits_q <= 4'h0; // [RULE17]
      else
         bits_q <= bits_q + 4'h1; // [RULE8]
   end

   // Input shift register samples din on the rising serial clock, MSB first.
   always_ff @(posedge sclk or posedge link_arst)
   begin
      if (link_arst)
         sin_q <= 7'h00;
      else if (!cs_n)
         sin_q <= byte_in[6:0]; // [RULE1] [RULE7] [RULE17]
   end

   // Transfer phase and communications register. A comms byte with its top bit
   // set is not a valid write and leaves the port waiting for the next one.
   always_ff @(posedge sclk or posedge link_arst)
   begin
      if (link_arst)
      begin
         phase_q <= PH_COMM;
         comm_q  <= 8'h00;
      end
      else if (!cs_n && last_bit)
      begin
         unique case (phase_q)
            PH_COMM:
            begin
               if (!byte_in[COMM_WEN_BIT])
               begin
                  comm_q <= byte_in; // [RULE1]
                  if (byte_in[COMM_RW_BIT])
                     phase_q <= PH_RD;
                  else if (byte_in[COMM_RS_MSB:COMM_RS_LSB] == RS_COMM)
                     phase_q <= PH_COMM;
                  else
                     phase_q <= PH_WR;
               end
            end
            PH_WR:
               phase_q <= PH_COMM;
            PH_RD:
               phase_q <= PH_COMM;
            default:
               phase_q <= PH_COMM;
         endcase
      end
   end

   // A finished write byte is parked and announced by a toggle; the host needs a
   // whole byte time before the next one, far longer than the crossing takes.
   always_ff @(posedge sclk or posedge link_arst)
   begin
      if (link_arst)
      begin
         wr_tgl_q  <= 1'b0;
         wr_sel_q  <= RS_COMM;
         wr_data_q <= 8'h00;
      end
      else if (!cs_n && last_bit && phase_q == PH_WR && rs_sel != RS_DATA)
      begin
         wr_sel_q  <= rs_sel; // [RULE1]
         wr_data_q <= byte_in;
         wr_tgl_q  <= ~wr_tgl_q;
      end
   end

   // A data read counts as done only on its sixteenth bit.
   always_ff @(posedge sclk or posedge link_arst)
   begin
      if (link_arst)
         rd_tgl_q <= 1'b0;
      else if (!cs_n && last_bit && phase_q == PH_RD && rs_sel == RS_DATA)
         rd_tgl_q <= ~rd_tgl_q; // [RULE10]
   end

   // Marks that the next falling edge must load the output shift register.
   always_ff @(posedge sclk or posedge link_arst)
   begin
      if (link_arst)
         rd_load_q <= 1'b0;
      else if (!cs_n)
         rd_load_q <= last_bit && phase_q == PH_COMM && !byte_in[COMM_WEN_BIT]
                      && byte_in[COMM_RW_BIT];
   end

   // Register words are read across domains without a handshake: setup and clock
   // only change by the host's own writes, a calibration end or the reset pin, and the host keeps
   // off the data register while the ready line is high.
   always_comb
   begin
      unique case (rs_sel)
         RS_SETUP: read_word = {setup_q, 8'h00};
         RS_CLOCK: read_word = {clock_q, 8'h00};
         RS_DATA:  read_word = data_q; // [RULE12]
         default:  read_word = {data_ready_n_link, comm_q[6:0], 8'h00};
      endcase
   end

   // Output shift register launches on the falling serial clock so the host can
   // sample on the rising one.
   always_ff @(negedge sclk or posedge link_arst)
   begin
      if (link_arst)
         sout_q <= 16'h0000;
      else if (!cs_n)
      begin
         if (rd_load_q)
            sout_q <= read_word; // [RULE2]
         else
            sout_q <= {sout_q[14:0], 1'b0}; // [RULE17]
      end
   end

   // Output only drives while selected, so several devices may share the line.
   assign dout    = sout_q[15];
   assign dout_oe = ~cs_n; // [RULE4] [RULE5]

   // Ready state seen from the link side, for the top bit of a comms read.
   asp_sync #(
      .RESET_VAL (1'b1)
   ) u_data_ready_n_sync (
      .clk (sclk),
      .rst (link_arst),
      .d   (data_ready_n_n_q),
      .q   (data_ready_n_link)
   );

   // Reset pin and link toggles brought onto the master clock.
   asp_sync #(
      .RESET_VAL (1'b1)
   ) u_pin_sync (
      .clk (mclk),
      .rst (rst),
      .d   (reset_n),
      .q   (pin_rst_n_s)
   );

   asp_sync #(
      .RESET_VAL (1'b0)
   ) u_wr_sync (
      .clk (mclk),
      .rst (rst),
      .d   (wr_tgl_q),
      .q   (wr_tgl_s)
   );

   asp_sync #(
      .RESET_VAL (1'b0)
   ) u_rd_sync (
      .clk (mclk),
      .rst (rst),
      .d   (rd_tgl_q),
      .q   (rd_tgl_s)
   );

   assign ctrl_rst = ~pin_rst_n_s;
   assign wr_ev    = (wr_tgl_s != wr_seen_q);
   assign rd_ev    = (rd_tgl_s != rd_seen_q);

   // Remember which toggles have been acted on.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wr_seen_q <= 1'b0;
         rd_seen_q <= 1'b0;
      end
      else
      begin
         wr_seen_q <= wr_tgl_s;
         rd_seen_q <= rd_tgl_s;
      end
   end

   // Calibration events derived from setup writes and the core's done pulse.
   assign cal_active = (setup_q[SETUP_MD_MSB:SETUP_MD_LSB] != MODE_NORMAL);
   assign cal_start  = wr_ev && wr_sel_q == RS_SETUP
                       && wr_data_q[SETUP_MD_MSB:SETUP_MD_LSB] != MODE_NORMAL;
   assign cal_fin    = cal_done && cal_active && !cal_start; // [RULE14]

   // Setup register; a finished calibration drops the mode back to normal by itself.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         setup_q <= SETUP_RST; // [RULE16]
      else if (ctrl_rst)
         setup_q <= SETUP_RST; // [RULE3] [RULE16]
      else if (wr_ev && wr_sel_q == RS_SETUP)
         setup_q <= wr_data_q; // [RULE1]
      else if (cal_fin)
         setup_q[SETUP_MD_MSB:SETUP_MD_LSB] <= MODE_NORMAL; // [RULE15]
   end

   // Clock register.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         clock_q <= CLOCK_RST;
      else if (ctrl_rst)
         clock_q <= CLOCK_RST; // [RULE3]
      else if (wr_ev && wr_sel_q == RS_CLOCK)
         clock_q <= wr_data_q; // [RULE1]
   end

   // New results are dropped during calibration and during a hold window; the
   // core is free running and the next result replaces them anyway.
   assign imm_commit = conv_valid && !hold_bus.busy && !cal_active && data_ready_n_n_q;
   assign hold_start = conv_valid && !hold_bus.busy && !cal_active && !data_ready_n_n_q; // [RULE11]
   assign commit     = imm_commit || hold_bus.done;

   assign hold_bus.start = hold_start;
   assign hold_bus.abort = ctrl_rst || cal_start;

   asp_hold_timer #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) u_hold (
      .clk (mclk),
      .rst (rst),
      .hi  (hold_bus)
   );

   // Result waiting out the hold window.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pend_q <= DATA_RST;
      else if (hold_start)
         pend_q <= conv_data;
   end

   // Data register update.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         data_q <= DATA_RST;
      else if (ctrl_rst)
         data_q <= DATA_RST; // [RULE3]
      else if (imm_commit)
         data_q <= conv_data; // [RULE13]
      else if (hold_bus.done)
         data_q <= pend_q; // [RULE11] [RULE13]
   end

   // Ready line. A new result or a calibration end wins over a read completing in
   // the same cycle, so no result is ever announced as consumed by mistake.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         data_ready_n_n_q <= 1'b1;
      else if (ctrl_rst)
         data_ready_n_n_q <= 1'b1; // [RULE3]
      else if (commit)
         data_ready_n_n_q <= 1'b0; // [RULE9] [RULE13]
      else if (cal_fin)
         data_ready_n_n_q <= 1'b0; // [RULE14] [RULE15]
      else if (cal_start || hold_start)
         data_ready_n_n_q <= 1'b1; // [RULE11] [RULE15]
      else if (rd_ev)
         data_ready_n_n_q <= 1'b1; // [RULE10]
   end

   // Filter and modulator reset follows the synchronised reset pin.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         filt_rst_q <= 1'b1;
      else
         filt_rst_q <= ctrl_rst; // [RULE3]
   end

   assign data_ready_n = data_ready_n_n_q;
   assign setup_reg    = setup_q;
   assign clock_reg    = clock_q;
   assign filter_reset = filt_rst_q;

endmodule

// ### pkg/asp_pkg.sv
// Constants, types and helpers for the converter serial port.
// Assumes one master clock domain and one serial-clock domain at the top.
//
// Behaviour
// [RULE1] Serial input bytes shift in, then land in the register the select bits pick.
// [RULE2] Serial output shifts from a word loaded from the selected register.
// [RULE3] Reset pin low returns control, interface and converter core to power-on state.
// [RULE4] Chip select is active low; serial traffic counts only while it is low.
// [RULE5] Chip select tied low gives a three-wire port of clock, input and output.
// [RULE6] Chip select may pick one device on a shared bus or frame each transfer.
// [RULE7] The host supplies the serial clock; it moves both write and read data.
// [RULE8] Serial clock may run continuously or in bursts; bytes still assemble right.
// [RULE9] Ready line goes low when a new result sits in the data register.
// [RULE10] Ready line goes high once a full output word has been read.
// [RULE11] Unread result: ready line high for 500 master clocks before the next update.
// [RULE12] Host must not start a data read while the ready line is high.
// [RULE13] Ready line goes low again once the data register update is done.
// [RULE14] Ready line also signals that calibration has finished.
// [RULE15] Calibration end returns to normal mode and shows as a ready falling edge.
// [RULE16] Setup register holds 01 hex at power-up.
// [RULE17] Transfers are whole bytes, MSB first, launched and sampled on opposite edges.
package asp_pkg;

   // Communications register fields.
   localparam int unsigned COMM_WEN_BIT = 7;
   localparam int unsigned COMM_RS_MSB  = 6;
   localparam int unsigned COMM_RS_LSB  = 4;
   localparam int unsigned COMM_RW_BIT  = 3;

   // Register select codes.
   localparam logic [2:0] RS_COMM  = 3'h0;
   localparam logic [2:0] RS_SETUP = 3'h1;
   localparam logic [2:0] RS_CLOCK = 3'h2;
   localparam logic [2:0] RS_DATA  = 3'h3;

   // Setup register operating-mode field and reset values.
   localparam int unsigned SETUP_MD_MSB = 7;
   localparam int unsigned SETUP_MD_LSB = 6;
   localparam logic [1:0]  MODE_NORMAL  = 2'h0;
   localparam logic [7:0]  SETUP_RST    = 8'h01;
   localparam logic [7:0]  CLOCK_RST    = 8'h00;
   localparam logic [15:0] DATA_RST     = 16'h0000;

   // Bit indexes of the last bit of a byte and of a data word.
   localparam logic [3:0] LAST_BYTE = 4'h7;
   localparam logic [3:0] LAST_WORD = 4'hF;

   // Master clock cycles the ready line stays high ahead of an unread update.
   localparam int unsigned HOLD_CYC = 500;

   typedef enum logic [1:0] {
      PH_COMM = 2'b00,
      PH_WR   = 2'b01,
      PH_RD   = 2'b11
   } asp_phase_t;

   // Index of the last bit in the current transfer.
   function automatic logic [3:0] asp_last_idx(asp_phase_t ph, logic [2:0] rs);
      return (ph == PH_RD && rs == RS_DATA) ? LAST_WORD : LAST_BYTE;
   endfunction

endpackage

// ### pkg/asp_hold_if.sv
// Handshake between the ready-line control and its hold timer.
// Assumes both ends run on the master clock.
`timescale 1ns/1ps
interface asp_hold_if;
   logic start;
   logic abort;
   logic busy;
   logic done;

   modport ctrl (output start, output abort, input busy, input done);
   modport tmr  (input start, input abort, output busy, output done);
endinterface

// ### verilog/asp_sync.sv
// Three-stage synchroniser with an agreement filter on the last two stages.
// Assumes d comes from another clock domain or a pin.
`timescale 1ns/1ps
module asp_sync #(
   parameter logic RESET_VAL = 1'b0
)(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage feeds only the second; the output moves once stages two and three agree.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         q    <= RESET_VAL;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q <= s3_q;
      end
   end
endmodule

// ### verilog/asp_hold_timer.sv
// Counts the ready-line hold window that precedes an update of an unread result.
// Assumes start is a one-cycle request from logic on the same clock.
`timescale 1ns/1ps
module asp_hold_timer
   import asp_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
)(
   input  wire logic clk,
   input  wire logic rst,
   asp_hold_if.tmr   hi
);
   localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

   logic          busy_q;
   logic [CW-1:0] cnt_q;

   // Done fires in the last cycle of the window, so the caller updates on the next edge.
   assign hi.busy = busy_q;
   assign hi.done = busy_q && (cnt_q == LAST) && !hi.abort; // [RULE11]

   // Window runs for exactly the hold count once started, unless an abort ends it first.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
      end
      else if (hi.abort)
      begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
      end
      else if (!busy_q)
      begin
         busy_q <= hi.start;
         cnt_q  <= '0;
      end
      else if (cnt_q == LAST)
      begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
      end
      else
         cnt_q <= cnt_q + CW'(1);
   end
endmodule

// ### bench/asp_serial_port_props.sv
// Concurrent checks on the ports of the converter serial port.
// Assumes it is bound to asp_serial_port and sees only that module's ports.
`timescale 1ns/1ps
module asp_serial_port_props #(
   parameter int unsigned HOLD_CYCLES = 500
)(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       cs_n,
   input wire logic       reset_n,
   input wire logic       dout_oe,
   input wire logic       data_ready_n,
   input wire logic       conv_valid,
   input wire logic       cal_done,
   input wire logic [7:0] setup_reg,
   input wire logic [7:0] clock_reg,
   input wire logic       filter_reset
);
   int unsigned hcnt_q;
   logic        mode0;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Normal mode is mode field 00; results are dropped in any other mode.
   assign mode0 = (setup_reg[7:6] == 2'h0);

   // Counts the hold window of an unread result. An abort by a mode write is not tracked,
   // so scenarios never abort a hold.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         hcnt_q <= 0;
      else if (conv_valid && !data_ready_n && mode0 && hcnt_q == 0)
         hcnt_q <= 1;
      else if (hcnt_q != 0 && hcnt_q <= HOLD_CYCLES)
         hcnt_q <= hcnt_q + 1;
      else
         hcnt_q <= 0;
   end

   sequence s_pin_reset;
      $fell(reset_n) ##0 (!reset_n)[*8];
   endsequence
   sequence s_unread;
      conv_valid && !data_ready_n && mode0 && hcnt_q == 0;
   endsequence

   property p_oe;
      dout_oe == !cs_n;
   endproperty
   property p_pin_reset;
      s_pin_reset |-> setup_reg == 8'h01 && clock_reg == 8'h00 && data_ready_n && filter_reset;
   endproperty
   property p_hold_rise;
      s_unread |=> data_ready_n;
   endproperty
   property p_hold_len;
      hcnt_q != 0 && hcnt_q <= HOLD_CYCLES |-> data_ready_n;
   endproperty
   property p_hold_end;
      hcnt_q == HOLD_CYCLES + 1 |-> !data_ready_n;
   endproperty
   property p_fresh;
      conv_valid && data_ready_n && mode0 && hcnt_q == 0 |=> !data_ready_n;
   endproperty
   property p_cal_end;
      cal_done && !mode0 |=> setup_reg[7:6] == 2'h0 && $fell(data_ready_n);
   endproperty
   property p_cs_quiet;
      (cs_n && reset_n)[*8] |-> $stable(clock_reg);
   endproperty

   a_oe: assert property (p_oe) else $error("output enable differs from select");
   a_pin_reset: assert property (p_pin_reset) else $error("pin reset state wrong");
   a_hold_rise: assert property (p_hold_rise) else $error("ready not high on hold");
   a_hold_len: assert property (p_hold_len) else $error("ready low inside hold");
   a_hold_end: assert property (p_hold_end) else $error("ready not low after hold");
   a_fresh: assert property (p_fresh) else $error("ready not low on result");
   a_cal_end: assert property (p_cal_end) else $error("calibration end wrong");
   a_cs_quiet: assert property (p_cs_quiet) else $error("register moved, no select");
endmodule

// ### bench/asp_host.sv
// Serial master model that clocks frames into and out of the port.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ps
module asp_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   logic three_wire = 1'b0;

   // Serial clock stands high outside frames and is never free running.
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // Sends nbits of tx MSB first, with an optional stall after every byte.
   task automatic xfer(input logic [23:0] tx, input int nbits, input int gap,
                       output logic [23:0] rx);
      rx = '0;
      #17;
      cs_n = 1'b0;
      #60;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         sclk = 1'b0;
         din = tx[i];
         #62.5;
         sclk = 1'b1;
         rx[i] = dout;
         #62.5;
         if (i % 8 == 0 && gap > 0)
            #(gap);
      end
      din = ~din;
      if (!three_wire)
         cs_n = 1'b1;
   endtask
endmodule

// ### bench/asp_serial_port_test.sv
// Self-checking bench for the converter serial port.
// Assumes the host model owns the serial pins and the bench drives the core side.
`timescale 1ns/1ps
module asp_serial_port_test;
   import asp_pkg::*;
   localparam int unsigned HC = 8;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        reset_n = 1'b1;
   logic        conv_valid = 1'b0;
   logic        cal_done = 1'b0;
   logic [15:0] conv_data = 16'h0000;
   logic        sclk, cs_n, din, dout, dout_oe, data_ready_n, filter_reset;
   logic [7:0]  setup_reg, clock_reg;
   logic [23:0] rx;
   int          n_errors = 0;
   int          checked = 0;
   int          cyc = 0;

   asp_serial_port #(.HOLD_CYCLES(HC)) dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .din(din), .reset_n(reset_n), .dout(dout), .dout_oe(dout_oe),
      .data_ready_n(data_ready_n), .conv_valid(conv_valid), .conv_data(conv_data),
      .cal_done(cal_done), .setup_reg(setup_reg), .clock_reg(clock_reg),
      .filter_reset(filter_reset));
   asp_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   always #25 mclk = ~mclk;

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic end_sim();
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic pulse_conv(input logic [15:0] d);
      @(negedge mclk);
      conv_data = d;
      conv_valid = 1'b1;
      @(negedge mclk);
      conv_valid = 1'b0;
   endtask

   task automatic t_reset_vals();
      chk(setup_reg, 8'h01, "setup reset");
      chk({clock_reg, data_ready_n, filter_reset, dout_oe}, 11'h004, "reset state");
      host.xfer(24'h1800, 16, 0, rx);
      chk(rx[7:0], 8'h01, "setup read");
   endtask
   // Bursty write, a refused command byte and a write to the read-only result.
   task automatic t_regs();
      host.xfer(24'h20A5, 16, 300, rx);
      tick(10);
      chk(clock_reg, 8'hA5, "clock write");
      host.xfer(24'hA0203C, 24, 0, rx);
      host.xfer(24'h30C3, 16, 0, rx);
      tick(10);
      chk({setup_reg, clock_reg}, 16'h013C, "refused bytes");
      host.xfer(24'h2800, 16, 0, rx);
      chk(rx[7:0], 8'h3C, "clock read");
   endtask
   // A comms write of its own register keeps the port waiting for a command; the
   // comms read that follows returns the ready state in its top bit.
   task automatic t_conv_read();
      pulse_conv(16'hC35A);
      tick(1);
      chk(data_ready_n, 1'b0, "ready on result");
      host.xfer(24'h000800, 24, 0, rx);
      chk(rx[7:0], 8'h08, "comms read");
      host.xfer(24'h380000, 24, 0, rx);
      chk(rx[15:0], 16'hC35A, "data read");
      tick(10);
      chk(data_ready_n, 1'b1, "ready after read");
   endtask
   // Unread result forces the hold window; a result inside it is dropped.
   task automatic t_hold();
      int hi;
      hi = 0;
      pulse_conv(16'h1234);
      tick(2);
      pulse_conv(16'h5678);
      repeat (3) if (data_ready_n !== 1'b1) tick(1);
      while (data_ready_n === 1'b1 && hi < 3 * HC)
      begin
         conv_valid = (hi == 3);
         conv_data = 16'h9999;
         hi++;
         tick(1);
      end
      chk(24'(hi), 24'(HC), "hold length");
      chk(data_ready_n, 1'b0, "ready after update");
      host.xfer(24'h380000, 24, 0, rx);
      chk(rx[15:0], 16'h5678, "held data");
   endtask
   task automatic t_cal();
      host.xfer(24'h1044, 16, 0, rx);
      tick(10);
      chk({setup_reg, data_ready_n}, 9'h089, "calibrating");
      @(negedge mclk);
      cal_done = 1'b1;
      tick(1);
      cal_done = 1'b0;
      tick(1);
      chk({setup_reg, data_ready_n}, 9'h008, "calibration end");
   endtask
   task automatic t_pin_reset();
      reset_n = 1'b0;
      tick(10);
      chk({setup_reg, clock_reg, data_ready_n, filter_reset}, 18'h00403, "pin reset");
      reset_n = 1'b1;
      tick(10);
      chk(filter_reset, 1'b0, "core released");
   endtask
   // Select tied low for good, so it runs last.
   task automatic t_three_wire();
      host.three_wire = 1'b1;
      host.xfer(24'h205C, 16, 0, rx);
      tick(10);
      chk(clock_reg, 8'h5C, "three-wire write");
      host.xfer(24'h2800, 16, 0, rx);
      chk(rx[7:0], 8'h5C, "three-wire read");
   endtask

   // A hang is cut short well beyond the fewer than a thousand cycles the run needs.
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         n_errors++;
         end_sim();
      end
   end

   initial
   begin
      tick(20);
      rst = 1'b0;
      tick(2);
      t_reset_vals();
      t_regs();
      t_conv_read();
      t_hold();
      t_cal();
      t_pin_reset();
      t_three_wire();
      end_sim();
   end
endmodule

bind asp_serial_port asp_serial_port_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
   .mclk(mclk), .rst(rst), .cs_n(cs_n), .reset_n(reset_n), .dout_oe(dout_oe),
   .data_ready_n(data_ready_n), .conv_valid(conv_valid), .cal_done(cal_done),
   .setup_reg(setup_reg), .clock_reg(clock_reg), .filter_reset(filter_reset));
